// ### hw/scc_channel_regs.sv
// per-channel control register slice with AXI4-Lite access
//
// What this block does
// - bit 1 of 0x10 makes framing error injection persistent; resets to zero.
// - bits 2..7 of 0x10 hold count of framing errors to inject.
// - bit 5 of 0x11 starts errors into A1A2 framing bytes.
// - bit 6 of 0x11 starts errors into B1 parity byte.
// - bit 7 of 0x11 starts remote-defect errors into K2 byte.
// - bit 5 of 0x12 enables RDI-L detect interrupt, reported elsewhere.
// - bit 6 of 0x12 enables out-of-frame interrupt, reported elsewhere.
// - bit 7 of 0x12 enables frame-aligned interrupt, reported elsewhere.
// - bit 4 of 0x13 selects receive rate: zero full, one half.
// - bit 5 of 0x13 selects transmit rate: zero full, one half.
// - bit 6 of 0x13 powers receiver up when one.
// - bit 7 of 0x13 powers transmitter up when one.
// - 0x14 bit 0 enables pre-emphasis; bits 1..3 set its level.
// - 0x14 bits 4..5 pick transmit termination; ignored in PCI Express mode.
// - 0x14 bits 6..7 set transmit driver swing.
// - 0x15 bit 2 routes receive inputs through boundary-scan path.
// - 0x15 bit 3 enables receive equalization; bit 5 sets level.
// - 0x15 bit 4 selects DC coupling when one, AC when zero.
// - 0x15 bits 6..7 pick receive termination.
`timescale 1ns/100ps
`default_nettype none
`include "scc_defines.svh"
module scc_channel_regs (
  // clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_reset,
  // axi4-lite write address
  input  wire logic [7:0]         i_s_axi_awaddr,
  input  wire logic               i_s_axi_awvalid,
  output logic                    o_s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]        i_s_axi_wdata,
  input  wire logic [3:0]         i_s_axi_wstrb,
  input  wire logic               i_s_axi_wvalid,
  output logic                    o_s_axi_wready,
  // axi4-lite write response
  output logic [1:0]              o_s_axi_bresp,
  output logic                    o_s_axi_bvalid,
  input  wire logic               i_s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]         i_s_axi_araddr,
  input  wire logic               i_s_axi_arvalid,
  output logic                    o_s_axi_arready,
  // axi4-lite read data
  output logic [31:0]             o_s_axi_rdata,
  output logic [1:0]              o_s_axi_rresp,
  output logic                    o_s_axi_rvalid,
  input  wire logic               i_s_axi_rready,
  // framing overhead timing and mode
  input  wire logic               i_frame_strobe,
  input  wire logic               i_pcie_mode,
  // error injection strobes toward transmit overhead logic
  output logic                    o_a1a2_inject,
  output logic                    o_b1_inject,
  output logic                    o_k2_rdi_inject,
  // framing interrupt enables toward the status block
  output logic                    o_ie_rdi_l,
  output logic                    o_ie_oof,
  output logic                    o_ie_in_frame,
  // serdes rate and power
  output logic                    o_rx_half_rate,
  output logic                    o_tx_half_rate,
  output logic                    o_rx_power_up,
  output logic                    o_tx_power_up,
  // transmit driver
  output logic                    o_tx_preemph_en,
  output logic [2:0]              o_tx_preemph_level,
  output logic [1:0]              o_tx_term_sel,
  output logic [1:0]              o_tx_swing_sel,
  // receive input
  output logic                    o_rx_bscan_route,
  output logic                    o_rx_eq_en,
  output logic                    o_rx_eq_level,
  output logic                    o_rx_dc_couple,
  output logic [1:0]              o_rx_term_sel
);
  import scc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address helpers, shared by the write and read paths

  function automatic scc_index_t addr_index(input logic [7:0] addr);
    addr_index = addr[7:2];
  endfunction : addr_index

  function automatic logic index_mapped(input scc_index_t idx);
    index_mapped = (idx >= `SCC_IDX_FRM_CNT && idx <= `SCC_IDX_RSVD) ||
                   (idx == `SCC_IDX_INJ_STAT);
  endfunction : index_mapped

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  scc_byte_t frm_cnt_r;
  scc_byte_t inj_start_r;
  scc_byte_t frm_irq_en_r;
  scc_byte_t rate_pwr_r;
  scc_byte_t tx_drv_r;
  scc_byte_t rx_in_r;

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  logic        aw_held_r;
  scc_index_t  aw_idx_r;
  logic        w_held_r;
  scc_byte_t   w_data_r;
  logic        w_lane0_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;

  wire aw_take   = i_s_axi_awvalid & ~aw_held_r;
  wire w_take    = i_s_axi_wvalid & ~w_held_r;
  // commit only when the previous response has gone, so nothing is lost
  wire wr_commit = aw_held_r & w_held_r & ~bvalid_r;
  wire wr_hit    = wr_commit & w_lane0_r;
  wire wr_ok     = index_mapped(aw_idx_r);

  wire wr_frm_cnt    = wr_hit & (aw_idx_r == `SCC_IDX_FRM_CNT);
  wire wr_inj_start  = wr_hit & (aw_idx_r == `SCC_IDX_INJ_START);
  wire wr_frm_irq_en = wr_hit & (aw_idx_r == `SCC_IDX_FRM_IRQ_EN);
  wire wr_rate_pwr   = wr_hit & (aw_idx_r == `SCC_IDX_RATE_PWR);
  wire wr_tx_drv     = wr_hit & (aw_idx_r == `SCC_IDX_TX_DRV);
  wire wr_rx_in      = wr_hit & (aw_idx_r == `SCC_IDX_RX_IN);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      aw_held_r <= 1'b0;
      aw_idx_r  <= `SCC_CNT_ZERO;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      aw_idx_r  <= addr_index(i_s_axi_awaddr);
    end else if (wr_commit) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      w_held_r  <= 1'b0;
      w_data_r  <= `SCC_RESET_VAL;
      w_lane0_r <= 1'b0;
    end else if (w_take) begin
      w_held_r  <= 1'b1;
      w_data_r  <= i_s_axi_wdata[7:0];
      w_lane0_r <= i_s_axi_wstrb[0];
    end else if (wr_commit) begin
      w_held_r  <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      bvalid_r <= 1'b0;
    end else if (wr_commit) begin
      bvalid_r <= 1'b1;
    end else if (i_s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      bresp_r <= `SCC_RESP_OKAY;
    end else if (wr_commit) begin
      bresp_r <= wr_ok ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
    end
  end

  // writable bits only; reserved bits stay zero
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      frm_cnt_r <= `SCC_RESET_VAL;
    end else if (wr_frm_cnt) begin
      frm_cnt_r <= w_data_r & `SCC_MASK_FRM_CNT;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      inj_start_r <= `SCC_RESET_VAL;
    end else if (wr_inj_start) begin
      inj_start_r <= w_data_r & `SCC_MASK_INJ_START;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      frm_irq_en_r <= `SCC_RESET_VAL;
    end else if (wr_frm_irq_en) begin
      frm_irq_en_r <= w_data_r & `SCC_MASK_FRM_IRQ_EN;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rate_pwr_r <= `SCC_RESET_VAL;
    end else if (wr_rate_pwr) begin
      rate_pwr_r <= w_data_r & `SCC_MASK_RATE_PWR;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_drv_r <= `SCC_RESET_VAL;
    end else if (wr_tx_drv) begin
      tx_drv_r <= w_data_r & `SCC_MASK_TX_DRV;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_in_r <= `SCC_RESET_VAL;
    end else if (wr_rx_in) begin
      rx_in_r <= w_data_r & `SCC_MASK_RX_IN;
    end
  end

  assign o_s_axi_awready = ~aw_held_r;
  assign o_s_axi_wready  = ~w_held_r;
  assign o_s_axi_bvalid  = bvalid_r;
  assign o_s_axi_bresp   = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // framing error injection

  scc_inject_if inj ();

  assign inj.persistent   = frm_cnt_r[`SCC_BIT_PERSIST];
  assign inj.count        = frm_cnt_r[`SCC_CNT_HI:`SCC_CNT_LO];
  assign inj.start        = inj_start_r[`SCC_BIT_A1A2_GO];
  assign inj.frame_strobe = i_frame_strobe;

  scc_frame_injector u_a1a2_inj (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .inj        (inj)
  );

  // b1 and k2 corrupt every frame while their start bit is set;
  // their own counts live in registers outside this slice
  logic b1_inject_r;
  logic k2_inject_r;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      b1_inject_r <= 1'b0;
    end else begin
      b1_inject_r <= i_frame_strobe & inj_start_r[`SCC_BIT_B1_GO];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      k2_inject_r <= 1'b0;
    end else begin
      k2_inject_r <= i_frame_strobe & inj_start_r[`SCC_BIT_K2_GO];
    end
  end

  assign o_a1a2_inject   = inj.inject;
  assign o_b1_inject     = b1_inject_r;
  assign o_k2_rdi_inject = k2_inject_r;

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire scc_index_t rd_idx  = addr_index(i_s_axi_araddr);
  wire             ar_take = i_s_axi_arvalid & ~rvalid_r;
  wire scc_byte_t  inj_stat = {inj.active, 1'b0, inj.remaining};

  wire rd_sel_frm_cnt    = (rd_idx == `SCC_IDX_FRM_CNT);
  wire rd_sel_inj_start  = (rd_idx == `SCC_IDX_INJ_START);
  wire rd_sel_frm_irq_en = (rd_idx == `SCC_IDX_FRM_IRQ_EN);
  wire rd_sel_rate_pwr   = (rd_idx == `SCC_IDX_RATE_PWR);
  wire rd_sel_tx_drv     = (rd_idx == `SCC_IDX_TX_DRV);
  wire rd_sel_rx_in      = (rd_idx == `SCC_IDX_RX_IN);
  wire rd_sel_inj_stat   = (rd_idx == `SCC_IDX_INJ_STAT);
  wire rd_ok             = index_mapped(rd_idx);

  // reserved offset and unused bits read as zero
  wire scc_byte_t rd_byte =
      rd_sel_frm_cnt    ? frm_cnt_r    :
      rd_sel_inj_start  ? inj_start_r  :
      rd_sel_frm_irq_en ? frm_irq_en_r :
      rd_sel_rate_pwr   ? rate_pwr_r   :
      rd_sel_tx_drv     ? tx_drv_r     :
      rd_sel_rx_in      ? rx_in_r      :
      rd_sel_inj_stat   ? inj_stat     :
                          `SCC_RESET_VAL;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rvalid_r <= 1'b0;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
    end else if (i_s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= {24'h000000, `SCC_RESET_VAL};
      rresp_r <= `SCC_RESP_OKAY;
    end else if (ar_take) begin
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_ok ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
    end
  end

  assign o_s_axi_arready = ~rvalid_r;
  assign o_s_axi_rvalid  = rvalid_r;
  assign o_s_axi_rdata   = rdata_r;
  assign o_s_axi_rresp   = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // configuration outputs

  assign o_ie_rdi_l    = frm_irq_en_r[`SCC_BIT_IE_RDI];
  assign o_ie_oof      = frm_irq_en_r[`SCC_BIT_IE_OOF];
  assign o_ie_in_frame = frm_irq_en_r[`SCC_BIT_IE_INFRM];

  assign o_rx_half_rate = rate_pwr_r[`SCC_BIT_RX_HALF];
  assign o_tx_half_rate = rate_pwr_r[`SCC_BIT_TX_HALF];
  assign o_rx_power_up  = rate_pwr_r[`SCC_BIT_RX_PWR];
  assign o_tx_power_up  = rate_pwr_r[`SCC_BIT_TX_PWR];

  assign o_tx_preemph_en    = tx_drv_r[`SCC_BIT_PREEMPH_EN];
  assign o_tx_preemph_level = tx_drv_r[`SCC_PREEMPH_HI:`SCC_PREEMPH_LO];
  // pci express owns termination; the stored code still reads back
  assign o_tx_term_sel = i_pcie_mode ? `SCC_TXTERM_DEFAULT
                                     : tx_drv_r[`SCC_TXTERM_HI:`SCC_TXTERM_LO];
  assign o_tx_swing_sel = tx_drv_r[`SCC_SWING_HI:`SCC_SWING_LO];

  assign o_rx_bscan_route = rx_in_r[`SCC_BIT_BSCAN];
  assign o_rx_eq_en       = rx_in_r[`SCC_BIT_EQ_EN];
  assign o_rx_eq_level    = rx_in_r[`SCC_BIT_EQ_LVL];
  assign o_rx_dc_couple   = rx_in_r[`SCC_BIT_DC_CPL];
  assign o_rx_term_sel    = rx_in_r[`SCC_RXTERM_HI:`SCC_RXTERM_LO];
endmodule : scc_channel_regs
`default_nettype wire

// ### hw/scc_defines.svh
// register offsets, field positions and reset values of the channel control slice
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH
// register indices; byte address is four times the index
`define SCC_IDX_FRM_CNT      6'h10
`define SCC_IDX_INJ_START    6'h11
`define SCC_IDX_FRM_IRQ_EN   6'h12
`define SCC_IDX_RATE_PWR     6'h13
`define SCC_IDX_TX_DRV       6'h14
`define SCC_IDX_RX_IN        6'h15
`define SCC_IDX_RSVD         6'h16
`define SCC_IDX_INJ_STAT     6'h1F
// writable bit masks per register
`define SCC_MASK_FRM_CNT     8'hFE
`define SCC_MASK_INJ_START   8'hE0
`define SCC_MASK_FRM_IRQ_EN  8'hE0
`define SCC_MASK_RATE_PWR    8'hF0
`define SCC_MASK_TX_DRV      8'hFF
`define SCC_MASK_RX_IN       8'hFC
`define SCC_RESET_VAL        8'h00
// field positions
`define SCC_BIT_PERSIST      1
`define SCC_CNT_HI           7
`define SCC_CNT_LO           2
`define SCC_BIT_A1A2_GO      5
`define SCC_BIT_B1_GO        6
`define SCC_BIT_K2_GO        7
`define SCC_BIT_IE_RDI       5
`define SCC_BIT_IE_OOF       6
`define SCC_BIT_IE_INFRM     7
`define SCC_BIT_RX_HALF      4
`define SCC_BIT_TX_HALF      5
`define SCC_BIT_RX_PWR       6
`define SCC_BIT_TX_PWR       7
`define SCC_BIT_PREEMPH_EN   0
`define SCC_PREEMPH_HI       3
`define SCC_PREEMPH_LO       1
`define SCC_TXTERM_HI        5
`define SCC_TXTERM_LO        4
`define SCC_TXTERM_DEFAULT   2'h0
`define SCC_SWING_HI         7
`define SCC_SWING_LO         6
`define SCC_BIT_BSCAN        2
`define SCC_BIT_EQ_EN        3
`define SCC_BIT_DC_CPL       4
`define SCC_BIT_EQ_LVL       5
`define SCC_RXTERM_HI        7
`define SCC_RXTERM_LO        6
// bus answers and count constants
`define SCC_RESP_OKAY        2'h0
`define SCC_RESP_SLVERR      2'h2
`define SCC_CNT_ZERO         6'h00
`define SCC_CNT_ONE          6'h01
`endif

// ### hw/scc_pkg.sv
// types shared by the channel control slice
package scc_pkg;
  typedef logic [7:0] scc_byte_t;
  typedef logic [5:0] scc_index_t;
  typedef logic [5:0] scc_count_t;
  typedef enum logic [0:0] {SCC_INJ_IDLE, SCC_INJ_RUN} scc_inj_state_t;
endpackage : scc_pkg

// ### hw/scc_inject_if.sv
// carrier between the register slice and the framing error injector
`timescale 1ns/100ps
`default_nettype none
interface scc_inject_if;
  import scc_pkg::*;
  logic       persistent;
  scc_count_t count;
  logic       start;
  logic       frame_strobe;
  logic       inject;
  scc_count_t remaining;
  logic       active;
  modport ctl (output persistent, output count, output start, output frame_strobe,
               input inject, input remaining, input active);
  modport eng (input persistent, input count, input start, input frame_strobe,
               output inject, output remaining, output active);
endinterface : scc_inject_if
`default_nettype wire

// ### hw/scc_frame_injector.sv
// framing byte error injector: counted or persistent, one error per frame
`timescale 1ns/100ps
`default_nettype none
`include "scc_defines.svh"
module scc_frame_injector (
  // clock and reset
  input wire logic    i_core_clk,
  input wire logic    i_reset,
  // control and result
  scc_inject_if.eng   inj
);
  import scc_pkg::*;

  scc_inj_state_t state_r;
  scc_inj_state_t state_nxt;
  scc_count_t     remaining_r;
  scc_count_t     remaining_nxt;
  logic           start_d_r;
  logic           inject_r;
  logic           inject_nxt;

  ////////////////////////////////////////////////////////////////////////////
  wire start_rise = inj.start & ~start_d_r;
  wire have_left  = inj.persistent | (remaining_r != `SCC_CNT_ZERO);
  wire fire       = (state_r == SCC_INJ_RUN) & inj.frame_strobe & have_left;

  always_comb begin
    state_nxt     = state_r;
    remaining_nxt = remaining_r;
    inject_nxt    = 1'b0;
    unique case (state_r)
      SCC_INJ_IDLE: begin
        if (start_rise) begin
          state_nxt     = SCC_INJ_RUN;
          remaining_nxt = inj.count;
        end
      end
      SCC_INJ_RUN: begin
        // clearing the start bit aborts at once
        if (!inj.start) begin
          state_nxt     = SCC_INJ_IDLE;
          remaining_nxt = `SCC_CNT_ZERO;
        end else if (fire) begin
          inject_nxt = 1'b1;
          if (!inj.persistent) begin
            remaining_nxt = remaining_r - `SCC_CNT_ONE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r     <= SCC_INJ_IDLE;
      remaining_r <= `SCC_CNT_ZERO;
      start_d_r   <= 1'b0;
      inject_r    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      remaining_r <= remaining_nxt;
      start_d_r   <= inj.start;
      inject_r    <= inject_nxt;
    end
  end

  assign inj.inject    = inject_r;
  assign inj.remaining = remaining_r;
  assign inj.active    = (state_r == SCC_INJ_RUN) & have_left;
endmodule : scc_frame_injector
`default_nettype wire

// ### bench/scc_regs_assertions.sv
// concurrent checks on bus answers and injection pulses of the channel control slice
`timescale 1ns/100ps
`default_nettype none
`include "scc_defines.svh"
module scc_regs_assertions (
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_reset,
  // register bus
  input wire logic [7:0]  i_s_axi_awaddr,
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_rvalid,
  // framing and serdes
  input wire logic        i_frame_strobe,
  input wire logic        i_pcie_mode,
  input wire logic        o_a1a2_inject,
  input wire logic        o_b1_inject,
  input wire logic        o_k2_rdi_inject,
  input wire logic [1:0]  o_tx_term_sel
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  // only valid while aw and w are offered together, as the bench does
  wire wr_go  = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  wire mapped = i_s_axi_awaddr[7:2] inside {[6'h10:6'h16], 6'h1F};
  ////////////////////////////////////////////////////////////////////////////////
  chk_term_forced: assert property (i_pcie_mode |-> o_tx_term_sel == 2'h0)
    else $error("tx termination not forced in pcie mode");
  chk_a1a2_cause: assert property (o_a1a2_inject |-> $past(i_frame_strobe))
    else $error("a1a2 pulse without frame strobe");
  chk_b1_cause: assert property (o_b1_inject |-> $past(i_frame_strobe))
    else $error("b1 pulse without frame strobe");
  chk_k2_cause: assert property (o_k2_rdi_inject |-> $past(i_frame_strobe))
    else $error("k2 pulse without frame strobe");
  chk_b_once: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("write response repeated");
  chk_rd_answer: assert property (i_s_axi_arvalid && o_s_axi_arready
    |=> o_s_axi_rvalid && !o_s_axi_arready)
    else $error("read answer late");
  chk_rdata_upper: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_wr_okay: assert property (wr_go && mapped
    |-> ##2 o_s_axi_bvalid && o_s_axi_bresp == `SCC_RESP_OKAY)
    else $error("mapped write answer wrong");
  chk_wr_slverr: assert property (wr_go && !mapped
    |-> ##2 o_s_axi_bvalid && o_s_axi_bresp == `SCC_RESP_SLVERR)
    else $error("unmapped write answer wrong");
endmodule : scc_regs_assertions
bind scc_channel_regs scc_regs_assertions u_chk (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
  .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
  .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp),
  .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rvalid(o_s_axi_rvalid),
  .i_frame_strobe(i_frame_strobe), .i_pcie_mode(i_pcie_mode), .o_a1a2_inject(o_a1a2_inject),
  .o_b1_inject(o_b1_inject), .o_k2_rdi_inject(o_k2_rdi_inject), .o_tx_term_sel(o_tx_term_sel));
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the channel control register slice
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import scc_pkg::*;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, fs = 0, pm = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0]  ws = 0;
  logic        awr, wr, bv, arr, rv, a1, b1, k2, ir, io, ii, rxh, txh, rxp, txp, pe, bs, eqe;
  logic        eql, dc;
  logic [1:0]  br, rr, tt, sw, rt;
  logic [2:0]  pl;
  scc_byte_t   m [6'h10:6'h16];
  scc_index_t  ix;
  int          n_fail = 0, n_compared = 0, np, nb, nk, k;
  int          cnts [4] = '{0, 1, 5, 63};
  always #20 clk = ~clk;
  scc_channel_regs dut (.i_core_clk(clk), .i_reset(rst), .i_s_axi_awaddr(awa),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bry), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
    .i_frame_strobe(fs), .i_pcie_mode(pm), .o_a1a2_inject(a1), .o_b1_inject(b1),
    .o_k2_rdi_inject(k2), .o_ie_rdi_l(ir), .o_ie_oof(io), .o_ie_in_frame(ii),
    .o_rx_half_rate(rxh), .o_tx_half_rate(txh), .o_rx_power_up(rxp), .o_tx_power_up(txp),
    .o_tx_preemph_en(pe), .o_tx_preemph_level(pl), .o_tx_term_sel(tt), .o_tx_swing_sel(sw),
    .o_rx_bscan_route(bs), .o_rx_eq_en(eqe), .o_rx_eq_level(eql), .o_rx_dc_couple(dc),
    .o_rx_term_sel(rt));
  ////////////////////////////////////////////////////////////////////////////////
  // writable bits per register; reserved bits stay zero
  function automatic scc_byte_t wm(input scc_index_t i);
    case (i)
      6'h10: return 8'hFE;
      6'h11, 6'h12: return 8'hE0;
      6'h13: return 8'hF0;
      6'h14: return 8'hFF;
      6'h15: return 8'hFC;
      default: return 8'h00;
    endcase
  endfunction : wm
  task automatic wr_reg(input scc_index_t i, input scc_byte_t d, input logic s, input logic [1:0] e);
    @(posedge clk);
    awa <= {i, 2'($urandom)};
    wd <= {24'($urandom), d};
    ws <= {3'($urandom), s};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
    end while (!bv);
    bry <= 0;
    `CHK({bv, br}, {1'b1, e})
    if (s && i >= 6'h10 && i <= 6'h16) m[i] = d & wm(i);
  endtask : wr_reg
  task automatic rd_reg(input scc_index_t i, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    ara <= {i, 2'($urandom)};
    arv <= 1;
    rry <= 1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
    end while (!rv);
    rry <= 0;
    `CHK({rv, rr, rd}, {1'b1, er, e})
  endtask : rd_reg
  task automatic chk_outs();
    `CHK({ii, io, ir}, m[6'h12][7:5])
    `CHK({txp, rxp, txh, rxh}, m[6'h13][7:4])
    `CHK({sw, tt, pl, pe}, m[6'h14])
    `CHK({rt, eql, dc, eqe, bs}, m[6'h15][7:2])
  endtask : chk_outs
  task automatic frame(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      fs <= 1;
      @(posedge clk);
      fs <= 0;
      #1;
      np += a1;
      nb += b1;
      nk += k2;
    end
  endtask : frame
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    void'($urandom(61131));
    foreach (m[i]) m[i] = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 0;
    for (ix = 6'h10; ix <= 6'h16; ix++) rd_reg(ix, 32'h0, 2'h0);
    chk_outs();
    $display("test reset values done");
    // all-ones and all-zeros first, then random bytes with lane 0 strobe off on every fourth write
    for (k = 0; k < 60; k++) begin
      ix = (k < 14) ? 6'(16 + k / 2) : 6'(16 + $urandom % 7);
      wr_reg(ix, (k < 14) ? ((k % 2) ? 8'h00 : 8'hFF) : 8'($urandom), k < 14 || k % 4 != 0, 2'h0);
      rd_reg(ix, {24'h0, m[ix]}, 2'h0);
      chk_outs();
    end
    wr_reg(6'h20, 8'hFF, 1'b1, 2'h2);
    rd_reg(6'h20, 32'h0, 2'h2);
    $display("test readback done");
    wr_reg(6'h14, 8'h10, 1'b1, 2'h0);
    @(posedge clk);
    pm <= 1;
    #1 `CHK(tt, 2'h0)
    @(posedge clk);
    pm <= 0;
    #1 `CHK(tt, 2'h1)
    $display("test pcie termination done");
    // counted runs at zero, one, five and the largest count, then persistent
    for (k = 0; k < 5; k++) begin
      wr_reg(6'h11, 8'h00, 1'b1, 2'h0);
      wr_reg(6'h10, (k < 4) ? 8'(cnts[k] << 2) : 8'h06, 1'b1, 2'h0);
      wr_reg(6'h11, 8'h20, 1'b1, 2'h0);
      {np, nb, nk} = '0;
      frame((k < 4) ? cnts[k] + 3 : 70);
      `CHK({np, nb, nk}, {(k < 4) ? cnts[k] : 32'd70, 32'd0, 32'd0})
      rd_reg(6'h1F, (k < 4) ? 32'h0 : 32'h81, 2'h0);
    end
    for (k = 0; k < 2; k++) begin
      wr_reg(6'h11, k ? 8'h80 : 8'h40, 1'b1, 2'h0);
      {np, nb, nk} = '0;
      frame(4);
      `CHK({np, nb, nk}, {32'd0, k ? 32'd0 : 32'd4, k ? 32'd4 : 32'd0})
    end
    $display("test injection done");
    wr_reg(6'h13, 8'hF0, 1'b1, 2'h0);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    foreach (m[i]) m[i] = 8'h00;
    rd_reg(6'h13, 32'h0, 2'h0);
    chk_outs();
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
